// File: rtl/amsm_pkg.sv
// Package for the converter input multiplexer slot mapping block
package amsm_pkg;
   // Printed register indices; the byte address is four times the index
   localparam int IDX_PRI_01 = 'h2090;
   localparam int IDX_PRI_23 = 'h2091;
   localparam int IDX_ALT_01 = 'h2096;
   localparam int IDX_ALT_23 = 'h2097;
   localparam int IDX_CTRL = 'h2098;
   localparam int IDX_STAT = 'h2099;
   localparam int IDX_SAMPLE = 'h2100;
   localparam logic [31:0] ADDR_PRI_01 = 32'(IDX_PRI_01 * 4);
   localparam logic [31:0] ADDR_PRI_23 = 32'(IDX_PRI_23 * 4);
   localparam logic [31:0] ADDR_ALT_01 = 32'(IDX_ALT_01 * 4);
   localparam logic [31:0] ADDR_ALT_23 = 32'(IDX_ALT_23 * 4);
   localparam logic [31:0] ADDR_CTRL = 32'(IDX_CTRL * 4);
   localparam logic [31:0] ADDR_STAT = 32'(IDX_STAT * 4);
   localparam logic [31:0] ADDR_SAMPLE = 32'(IDX_SAMPLE * 4);
   // Sample window: 16 words, one per input code
   localparam int SAMPLE_WORDS = 16;
   localparam int SAMPLE_LSB = 6;
   // Nibble positions inside each slot-pair byte
   localparam int LO_NIB = 0;
   localparam int HI_NIB = 4;
   // Control and status fields
   localparam int CTRL_ALT_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int STAT_SLOT_LSB = 0;
   localparam int STAT_FRAME_BIT = 2;
   localparam int STAT_CODE_LSB = 4;
   // Reset and wake values of the slot-pair bytes
   localparam logic [7:0] RST_PRI_01 = 8'h10;
   localparam logic [7:0] RST_PRI_23 = 8'h32;
   localparam logic [7:0] RST_ALT_01 = 8'h1A;
   localparam logic [7:0] RST_ALT_23 = 8'h32;
   localparam logic [7:0] WAKE_PRI_01 = 8'h10;
   localparam logic [7:0] WAKE_PRI_23 = 8'h32;
   localparam logic [7:0] WAKE_ALT_01 = 8'h1A;
   localparam logic [7:0] WAKE_ALT_23 = 8'hB2;
   localparam logic [1:0] RST_CTRL = 2'h0;
   // Extra input codes of the alternate frame
   localparam logic [3:0] CODE_TEMP = 4'hA;
   localparam logic [3:0] CODE_VBAT = 4'hB;
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int SAMPLE_W = 22;
   typedef enum logic {AMSM_FRAME_PRI, AMSM_FRAME_ALT} amsm_frame_e;
   // Captured address phase of a bus transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } amsm_aphase_s;
   // Converter result carrier
   typedef struct packed {
      logic done;
      logic [SAMPLE_W-1:0] data;
   } amsm_sample_s;
endpackage

// File: rtl/amsm_top.sv
// Slot mapping of analog inputs onto the converter multiplexer, with AHB-Lite registers
`timescale 1ns/1ps
module amsm_top
   import amsm_pkg::*;
#(
   parameter int SW = amsm_pkg::SAMPLE_W
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic WAKE,
   input wire amsm_pkg::amsm_sample_s CONV,
   output logic [3:0] MUX_SEL,
   output logic [1:0] MUX_SLOT,
   output logic MUX_FRAME
);
   import amsm_pkg::*;

   logic [7:0] pri_01;
   logic [7:0] pri_23;
   logic [7:0] alt_01;
   logic [7:0] alt_23;
   logic [1:0] ctrl;
   amsm_aphase_s aph;
   logic wake_s1;
   logic wake_s2;
   logic wake_s3;
   logic [SW-1:0] sample_mem [SAMPLE_WORDS];
   logic [1:0] slot;
   amsm_frame_e frame;

   // Address phase is taken only for word-sized transfers
   wire a_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);
   wire wr = aph.valid && aph.write;
   wire wr_pri_01 = wr && (aph.addr == ADDR_PRI_01);
   wire wr_pri_23 = wr && (aph.addr == ADDR_PRI_23);
   wire wr_alt_01 = wr && (aph.addr == ADDR_ALT_01);
   wire wr_alt_23 = wr && (aph.addr == ADDR_ALT_23);
   wire wr_ctrl = wr && (aph.addr == ADDR_CTRL);
   wire [7:0] wbyte = HWDATA[7:0];
   wire in_samples = (HADDR[31:SAMPLE_LSB] == ADDR_SAMPLE[31:SAMPLE_LSB]);
   wire [3:0] samp_idx = HADDR[SAMPLE_LSB-1:2];

   // Wake pin crosses in through two flops; the third only delays for the edge
   wire wake_evt = wake_s2 && !wake_s3;

   // Next read word, chosen in the address phase so that HRDATA comes from a flop
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h00000000;
      if (HADDR == ADDR_PRI_01) begin
         next_rdata = {24'h000000, pri_01};
      end else if (HADDR == ADDR_PRI_23) begin
         next_rdata = {24'h000000, pri_23};
      end else if (HADDR == ADDR_ALT_01) begin
         next_rdata = {24'h000000, alt_01};
      end else if (HADDR == ADDR_ALT_23) begin
         next_rdata = {24'h000000, alt_23};
      end else if (HADDR == ADDR_CTRL) begin
         next_rdata = {30'h00000000, ctrl};
      end else if (HADDR == ADDR_STAT) begin
         next_rdata = {24'h000000, MUX_SEL, 1'b0, MUX_FRAME, MUX_SLOT};
      end else if (in_samples) begin
         next_rdata = 32'(sample_mem[samp_idx]);
      end
   end

   // Bus slave: always ready, always OKAY, address phase captured for the data phase
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aph <= '0;
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         aph <= '{valid: a_take, write: HWRITE, addr: HADDR};
         HRDATA <= (a_take && !HWRITE) ? next_rdata : 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // Wake synchroniser
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         wake_s1 <= 1'b0;
         wake_s2 <= 1'b0;
         wake_s3 <= 1'b0;
      end else begin
         wake_s1 <= WAKE;
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
      end
   end

   // Primary slot fields; slot zero is the low nibble of the first byte
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pri_01 <= RST_PRI_01;
         pri_23 <= RST_PRI_23;
      end else if (wake_evt) begin
         pri_01 <= WAKE_PRI_01;
         pri_23 <= WAKE_PRI_23;
      end else begin
         if (wr_pri_01) begin
            pri_01 <= wbyte;
         end
         if (wr_pri_23) begin
            pri_23 <= wbyte;
         end
      end
   end

   // Alternate slot fields; wake gives slot three the battery code, reset does not
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         alt_01 <= RST_ALT_01;
         alt_23 <= RST_ALT_23;
      end else if (wake_evt) begin
         alt_01 <= WAKE_ALT_01;
         alt_23 <= WAKE_ALT_23;
      end else begin
         if (wr_alt_01) begin
            alt_01 <= wbyte;
         end
         if (wr_alt_23) begin
            alt_23 <= wbyte;
         end
      end
   end

   // Frame select and run enable
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ctrl <= RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl <= HWDATA[1:0];
      end
   end

   // Slot field lookup for the frame in force; all four nibbles are full codes
   wire [15:0] pri_slots = {pri_23, pri_01};
   wire [15:0] alt_slots = {alt_23, alt_01};
   wire running = ctrl[CTRL_RUN_BIT];
   wire [1:0] next_slot = (running && CONV.done) ? 2'(slot + 2'h1) : (running ? slot : 2'h0);
   // Frame changes only at the start of a cycle so a cycle never mixes frames
   wire frame_load = (next_slot == 2'h0) && (slot != 2'h0 || !running);
   wire next_alt = frame_load ? ctrl[CTRL_ALT_BIT] : (frame == AMSM_FRAME_ALT);
   wire [15:0] slots_used = next_alt ? alt_slots : pri_slots;
   wire [3:0] next_code = slots_used[4*next_slot +: 4];

   // Sequencer: advances one slot per finished conversion, in slot order
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         slot <= 2'h0;
         frame <= AMSM_FRAME_PRI;
         MUX_SEL <= RST_PRI_01[LO_NIB +: 4];
         MUX_SLOT <= 2'h0;
         MUX_FRAME <= 1'b0;
      end else begin
         slot <= next_slot;
         frame <= next_alt ? AMSM_FRAME_ALT : AMSM_FRAME_PRI;
         MUX_SEL <= next_code;
         MUX_SLOT <= next_slot;
         MUX_FRAME <= next_alt;
      end
   end

   // Result lands at the word of the input code, not of the slot
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int i = 0; i < SAMPLE_WORDS; i++) begin
            sample_mem[i] <= '0;
         end
      end else if (running && CONV.done) begin
         sample_mem[MUX_SEL] <= CONV.data;
      end
   end
endmodule

// File: bench/amsm_monitor.sv
// Port-level checker of the slot mapping block
`timescale 1ns/1ps
module amsm_monitor
   import amsm_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic HREADY,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire amsm_pkg::amsm_sample_s CONV,
   input wire logic [3:0] MUX_SEL,
   input wire logic [1:0] MUX_SLOT,
   input wire logic MUX_FRAME
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // Cycles with no read transfer of any size, and with no finished conversion
   sequence s_no_rd;
      !(HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE);
   endsequence
   sequence s_no_done;
      !CONV.done;
   endsequence
   property p_rd_idle;
      s_no_rd |=> HRDATA == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
   property p_okay;
      HREADYOUT && !HRESP;
   endproperty
   a_okay: assert property (p_okay) else $error("bus stalled or errored");
   property p_reset_sel;
      $fell(RST) |=> MUX_SEL == 4'h0 && !MUX_FRAME;
   endproperty
   a_reset_sel: assert property (p_reset_sel) else $error("slot zero not input 0");
   property p_slot_step;
      $changed(MUX_SLOT) |-> MUX_SLOT == $past(MUX_SLOT) + 2'h1;
   endproperty
   a_slot_step: assert property (p_slot_step) else $error("slot out of order");
   property p_step_cause;
      s_no_done |=> $stable(MUX_SLOT);
   endproperty
   a_step_cause: assert property (p_step_cause) else $error("slot moved without done");
   property p_frame_hold;
      $changed(MUX_FRAME) |-> MUX_SLOT == 2'h0;
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("frame changed mid frame");
endmodule

// File: bench/amsm_conv_model.sv
// Behavioural converter front end giving done pulses and samples
`timescale 1ns/1ps
module amsm_conv_model
   import amsm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] sel,
   input wire logic [7:0] gap,
   output amsm_pkg::amsm_sample_s conv
);
   logic [7:0] cnt;
   logic done;
   logic [21:0] junk;
   // A conversion lasts gap+1 cycles, so gap 0 answers every cycle
   always_ff @(posedge clk) begin
      cnt <= (rst || cnt >= gap) ? 8'h0 : cnt + 8'h1;
      done <= !rst && cnt >= gap;
      junk <= rst ? 22'h15555 : ~junk;
   end
   // Data name the selected code only while done; else they toggle
   assign conv = '{done: done, data: done ? {sel, 18'h2AB5} : junk};
endmodule

// File: bench/amsm_tb_top.sv
// Testbench of the slot mapping block
`timescale 1ns/1ps
module amsm_tb_top;
   import amsm_pkg::*;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic HSEL = 1'b1;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic WAKE = 1'b0;
   logic [7:0] gap = 8'h4;
   logic HREADYOUT, HRESP, MUX_FRAME;
   logic [31:0] HRDATA;
   logic [3:0] MUX_SEL;
   logic [1:0] MUX_SLOT;
   amsm_sample_s CONV;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   amsm_top u_dut (.CLOCK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(HSIZE_WORD), .HWDATA,
      .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .WAKE, .CONV, .MUX_SEL, .MUX_SLOT,
      .MUX_FRAME);
   amsm_conv_model u_conv (.clk(CLOCK), .rst(RST), .sel(MUX_SEL), .gap, .conv(CONV));
   // 50 ns clock
   initial forever #25 CLOCK = ~CLOCK;
   // Cut a hang short
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; waits on ready in both phases
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge CLOCK);
      HTRANS <= HTRANS_NONSEQ;
      HADDR <= a;
      HWRITE <= w;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   function automatic logic [31:0] smp(input int c);
      return 32'({4'(c), 18'h2AB5});
   endfunction
   // Let a number of conversions finish
   task automatic convs(input int n);
      repeat (n) @(posedge CLOCK iff CONV.done);
   endtask
   initial begin
      repeat (6) @(posedge CLOCK);
      RST <= 1'b0;
      rd(ADDR_PRI_01, 32'h10);
      rd(ADDR_PRI_23, 32'h32);
      rd(ADDR_ALT_01, 32'h1A);
      rd(ADDR_ALT_23, 32'h32);
      rd(ADDR_SAMPLE + 32'h40, 32'h0);
      // Wake loads the battery code into alternate slot three
      wr(ADDR_PRI_01, 32'hFFFF_FF23);
      rd(ADDR_PRI_01, 32'h23);
      WAKE <= 1'b1;
      repeat (4) @(posedge CLOCK);
      WAKE <= 1'b0;
      rd(ADDR_ALT_23, 32'hB2);
      rd(ADDR_PRI_01, 32'h10);
      // Reversed primary mapping, slow converter
      wr(ADDR_PRI_01, 32'h23);
      wr(ADDR_PRI_23, 32'h01);
      wr(ADDR_CTRL, 32'h2);
      convs(8);
      wr(ADDR_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) rd(ADDR_SAMPLE + 32'(4 * i), smp(i));
      rd(ADDR_SAMPLE + 32'h28, 32'h0);
      // Alternate frame, converter answering every cycle
      gap <= 8'h0;
      wr(ADDR_CTRL, 32'h3);
      convs(12);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_SAMPLE + 32'h28, smp(10));
      rd(ADDR_SAMPLE + 32'h2C, smp(11));
      test_done();
   end
endmodule
bind amsm_top amsm_monitor u_mon (.CLOCK, .RST, .HSEL, .HREADY, .HTRANS, .HWRITE, .HRDATA,
   .HREADYOUT, .HRESP, .CONV, .MUX_SEL, .MUX_SLOT, .MUX_FRAME);
